// [dma_pin_device.sv]
// device end: apb registers, dma handshake pins, ready pin and interrupt pin
`timescale 1ns/1ns
`include "dma_pin_consts.svh"
module dma_pin_device import dma_pin_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int CNT_W  = `CMD_CNT_W
) (
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic                   irq_out,
  input  wire logic              core_busy_in,
  input  wire logic              dma_req_in,
  output logic                   rd_strobe_out,
  output logic                   wr_strobe_out,
  output logic                   eot_out,
  dma_pins_if.device             pins
);

  if (ADDR_W < 8 || CNT_W < 1 || CNT_W > `CMD_CNT_W) begin : g_bad_param
    $error("ADDR_W must be >= 8 and CNT_W 1..16");
  end

  // ========================================================================
  // decode helpers
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return a == ADDR_W'(`OFS_CTRL) || a == ADDR_W'(`OFS_MASK) ||
           a == ADDR_W'(`OFS_STATUS) || a == ADDR_W'(`OFS_CMD);
  endfunction : mapped

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction : hit

  // ========================================================================
  // state
  logic [`CTRL_W-1:0] ctrl, next_ctrl;
  logic [`ST_W-1:0]   mask, next_mask;
  logic [`ST_W-1:0]   status, next_status;
  logic [31:0]        prdata, next_prdata;
  dev_state_t         state, next_state;
  logic [7:0]         tcnt, next_tcnt;
  logic [CNT_W-1:0]   words, next_words;
  logic               da2, next_da2;
  logic               rd_dir, next_rd_dir;
  logic               dior_q, next_dior_q;
  logic               diow_q, next_diow_q;
  logic               rd_p, next_rd_p;
  logic               wr_p, next_wr_p;
  logic               eot_q, next_eot_q;

  logic               master, split;
  logic               wr_acc, cmd_wr;
  logic               dreq_act, dack_in, dior_in, diow_in, eot_act;
  logic               dack_act, dior_act, diow_act;
  logic [`ST_W-1:0]   st_set;

  assign master  = ctrl[`CTRL_MASTER];
  assign split   = ctrl[`CTRL_SPLIT];
  assign wr_acc  = psel_in && penable_in && pwrite_in;
  assign cmd_wr  = wr_acc && hit(paddr_in, `OFS_CMD);

  // ========================================================================
  // pin sampling
  assign dreq_act = master && pin_active(pins.dreq, ctrl[`CTRL_DREQ_POL]);
  assign dack_in  = !master && pin_active(pins.dack, ctrl[`CTRL_DACK_POL]);
  assign dior_in  = !master && pin_active(pins.dior, ctrl[`CTRL_DIOR_POL]);
  assign diow_in  = !master && pin_active(pins.diow, ctrl[`CTRL_DIOW_POL]);
  assign eot_act  = !master && pin_active(pins.end_of_transfer_in, ctrl[`CTRL_EOT_POL]);

  // ========================================================================
  // master engine and pio access
  always_comb begin
    next_state  = state;
    next_tcnt   = tcnt;
    next_words  = words;
    next_da2    = da2;
    next_rd_dir = rd_dir;
    st_set      = '0;
    unique case (state)
      S_IDLE: begin
        // pio needs split bus and master, the strobes point at the disk then
        if (cmd_wr && pwdata_in[`CMD_PIO] && split && master) begin
          next_state  = S_PIO;
          next_tcnt   = 8'h00;
          next_da2    = pwdata_in[`CMD_DA2];
          next_rd_dir = ctrl[`CTRL_READ];
        end else if (cmd_wr && !pwdata_in[`CMD_PIO] && master &&
                     pwdata_in[CNT_W-1:0] != '0) begin
          next_state  = S_WAIT_REQ;
          next_words  = pwdata_in[CNT_W-1:0];
          next_rd_dir = ctrl[`CTRL_READ];
        end
      end
      S_WAIT_REQ: begin
        if (!master) begin
          next_state = S_IDLE;
        end else if (dreq_act) begin
          next_state = S_ACK;
        end
      end
      S_ACK: begin
        next_state = S_STROBE;
        next_tcnt  = 8'h00;
      end
      S_STROBE: begin
        next_tcnt = tcnt + 8'h01;
        if (tcnt == 8'(`STROBE_CYC - 1)) begin
          next_state = S_RECOVER;
          next_tcnt  = 8'h00;
          next_words = words - CNT_W'(1);
        end
      end
      S_RECOVER: begin
        next_tcnt = tcnt + 8'h01;
        if (tcnt == 8'(`RECOVER_CYC - 1)) begin
          next_tcnt = 8'h00;
          if (words == '0) begin
            next_state       = S_IDLE;
            st_set[`ST_DONE] = 1'b1;
          end else if (dreq_act) begin
            next_state = S_STROBE;
          end else begin
            next_state = S_WAIT_REQ;
          end
        end
      end
      S_PIO: begin
        if (tcnt < 8'(`STROBE_CYC - 1)) begin
          next_tcnt = tcnt + 8'h01;
        end else if (pins.ready) begin
          // a slow disk stretches the strobe by holding the shared pin low
          next_state      = S_IDLE;
          st_set[`ST_PIO] = 1'b1;
        end
      end
      // two of the eight state codes are unused, fall back to idle
      default: next_state = S_IDLE;
    endcase
    st_set[`ST_EOT]   = eot_act;
    st_set[`ST_INTRQ] = pins.intrq;
  end

  // ========================================================================
  // register file and slave strobe reporting
  always_comb begin
    next_ctrl   = ctrl;
    next_mask   = mask;
    next_prdata = prdata;
    if (wr_acc && hit(paddr_in, `OFS_CTRL)) begin
      next_ctrl = pwdata_in[`CTRL_W-1:0];
    end
    if (wr_acc && hit(paddr_in, `OFS_MASK)) begin
      next_mask = pwdata_in[`ST_W-1:0];
    end
    // set beats the one-to-clear write in the same cycle
    next_status = status | st_set;
    if (wr_acc && hit(paddr_in, `OFS_STATUS)) begin
      next_status = (status & ~pwdata_in[`ST_W-1:0]) | st_set;
    end
    if (psel_in && !penable_in && !pwrite_in) begin
      next_prdata = 32'h0000_0000;
      if (hit(paddr_in, `OFS_CTRL)) next_prdata[`CTRL_W-1:0] = ctrl;
      if (hit(paddr_in, `OFS_MASK)) next_prdata[`ST_W-1:0] = mask;
      if (hit(paddr_in, `OFS_STATUS)) next_prdata[`ST_W-1:0] = status;
      if (hit(paddr_in, `OFS_CMD)) begin
        next_prdata[CNT_W-1:0]   = words;
        next_prdata[`CMD_PIO]    = state == S_PIO;
        next_prdata[`CMD_DA2]    = da2;
        next_prdata[`CMD_DA2+1]  = state != S_IDLE;
      end
    end
    next_dior_q = dior_in;
    next_diow_q = diow_in;
    // an external controller transfer counts only with acknowledge active
    next_rd_p   = dack_in && dior_in && !dior_q;
    next_wr_p   = dack_in && diow_in && !diow_q;
    next_eot_q  = eot_act;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl   <= `CTRL_RST;
      mask   <= '0;
      status <= '0;
      prdata <= 32'h0000_0000;
      state  <= S_IDLE;
      tcnt   <= 8'h00;
      words  <= '0;
      da2    <= 1'b0;
      rd_dir <= 1'b0;
      dior_q <= 1'b0;
      diow_q <= 1'b0;
      rd_p   <= 1'b0;
      wr_p   <= 1'b0;
      eot_q  <= 1'b0;
    end else begin
      ctrl   <= next_ctrl;
      mask   <= next_mask;
      status <= next_status;
      prdata <= next_prdata;
      state  <= next_state;
      tcnt   <= next_tcnt;
      words  <= next_words;
      da2    <= next_da2;
      rd_dir <= next_rd_dir;
      dior_q <= next_dior_q;
      diow_q <= next_diow_q;
      rd_p   <= next_rd_p;
      wr_p   <= next_wr_p;
      eot_q  <= next_eot_q;
    end
  end

  // ========================================================================
  // bus answers
  assign pready_out    = 1'b1;
  assign pslverr_out   = psel_in && penable_in && !mapped(paddr_in);
  assign prdata_out    = prdata;
  assign irq_out       = |(status & mask);
  assign rd_strobe_out = rd_p;
  assign wr_strobe_out = wr_p;
  assign eot_out       = eot_q;

  // ========================================================================
  // pin drivers
  assign dack_act = state == S_ACK || state == S_STROBE || state == S_RECOVER;
  assign dior_act = rd_dir && (state == S_STROBE || state == S_PIO);
  assign diow_act = !rd_dir && (state == S_STROBE || state == S_PIO);

  // slave mode request stops as soon as the controller signals the end
  assign pins.dreq_dev      = pin_level(dma_req_in && !eot_act,
                                        ctrl[`CTRL_DREQ_POL]);
  assign pins.dreq_dev_oe_n = master;
  assign pins.dack_dev      = pin_level(dack_act, ctrl[`CTRL_DACK_POL]);
  assign pins.dack_dev_oe_n = !master;
  assign pins.dior_dev      = pin_level(dior_act, ctrl[`CTRL_DIOR_POL]);
  assign pins.dior_dev_oe_n = !master;
  assign pins.diow_dev      = pin_level(diow_act, ctrl[`CTRL_DIOW_POL]);
  assign pins.diow_dev_oe_n = !master;
  assign pins.ready_dev     = !(core_busy_in || state != S_IDLE);
  assign pins.ready_dev_oe_n = split;
  assign pins.da2           = da2;

  int_pin_drive #(
    .PULSE_CYC (`INT_PULSE_CYC)
  ) u_int (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .req_in   (irq_out),
    .pol_in   (ctrl[`CTRL_INT_POL]),
    .edge_in  (ctrl[`CTRL_INT_EDGE]),
    .pin_out  (pins.intr)
  );
endmodule : dma_pin_device

// [dma_pin_consts.svh]
// constants for the dma handshake pin block: offsets, fields, resets, timing
`ifndef DMA_PIN_CONSTS_SVH
`define DMA_PIN_CONSTS_SVH

// ==========================================================================
// register byte offsets
`define OFS_CTRL    8'h00
`define OFS_MASK    8'h04
`define OFS_STATUS  8'h08
`define OFS_CMD     8'h0c

// ==========================================================================
// control fields
`define CTRL_MASTER   0
`define CTRL_DREQ_POL 1
`define CTRL_DACK_POL 2
`define CTRL_DIOR_POL 3
`define CTRL_DIOW_POL 4
`define CTRL_EOT_POL  5
`define CTRL_INT_POL  6
`define CTRL_INT_EDGE 7
`define CTRL_SPLIT    8
`define CTRL_READ     9
`define CTRL_W        10
`define CTRL_RST      10'h002

// ==========================================================================
// status and mask fields
`define ST_DONE  0
`define ST_EOT   1
`define ST_INTRQ 2
`define ST_PIO   3
`define ST_W     4

// ==========================================================================
// command fields
`define CMD_CNT_W 16
`define CMD_PIO   16
`define CMD_DA2   17

// ==========================================================================
// far end polarity vector positions
`define POL_DREQ 0
`define POL_DACK 1
`define POL_DIOR 2
`define POL_DIOW 3
`define POL_EOT  4

// ==========================================================================
// timing
`define CLK_PERIOD_NS 10
`define STROBE_NS     30
`define STROBE_CYC    ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_NS    20
`define RECOVER_CYC   ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INT_PULSE_NS  40
`define INT_PULSE_CYC ((`INT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [dma_pin_pkg.sv]
// types and pin polarity helpers shared by both ends
package dma_pin_pkg;

  typedef enum logic [2:0] {
    S_IDLE, S_WAIT_REQ, S_ACK, S_STROBE, S_RECOVER, S_PIO
  } dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE, H_ACK, H_STROBE, H_HOLD
  } far_state_t;

  // pol 1 means active high
  function automatic logic pin_level(input logic active, input logic pol);
    return ~(active ^ pol);
  endfunction : pin_level

  function automatic logic pin_active(input logic level, input logic pol);
    return ~(level ^ pol);
  endfunction : pin_active

endpackage : dma_pin_pkg

// [dma_pins_if.sv]
// pin bundle joining the device end and the far end, with wire resolution
`timescale 1ns/1ns
interface dma_pins_if;
  logic dreq_dev, dreq_dev_oe_n, dreq_far, dreq_far_oe_n, dreq;
  logic dack_dev, dack_dev_oe_n, dack_far, dack_far_oe_n, dack;
  logic dior_dev, dior_dev_oe_n, dior_far, dior_far_oe_n, dior;
  logic diow_dev, diow_dev_oe_n, diow_far, diow_far_oe_n, diow;
  logic ready_dev, ready_dev_oe_n, ready_far, ready_far_oe_n, ready;
  logic end_of_transfer_in;
  logic intrq;
  logic intr;
  logic da2;

  // ========================================================================
  // undriven pins fall to their board pull levels
  assign dreq  = !dreq_dev_oe_n ? dreq_dev : !dreq_far_oe_n ? dreq_far : 1'b0;
  assign dack  = !dack_dev_oe_n ? dack_dev : !dack_far_oe_n ? dack_far : 1'b1;
  assign dior  = !dior_dev_oe_n ? dior_dev : !dior_far_oe_n ? dior_far : 1'b1;
  assign diow  = !diow_dev_oe_n ? diow_dev : !diow_far_oe_n ? diow_far : 1'b1;
  assign ready = !ready_dev_oe_n ? ready_dev : !ready_far_oe_n ? ready_far : 1'b1;

  modport device (
    input  dreq, dack, dior, diow, ready, end_of_transfer_in, intrq,
    output dreq_dev, dreq_dev_oe_n, dack_dev, dack_dev_oe_n,
    output dior_dev, dior_dev_oe_n, diow_dev, diow_dev_oe_n,
    output ready_dev, ready_dev_oe_n, intr, da2
  );

  modport far (
    input  dreq, dack, dior, diow, ready, intr, da2,
    output dreq_far, dreq_far_oe_n, dack_far, dack_far_oe_n,
    output dior_far, dior_far_oe_n, diow_far, diow_far_oe_n,
    output ready_far, ready_far_oe_n, end_of_transfer_in, intrq
  );
endinterface : dma_pins_if

// [int_pin_drive.sv]
// interrupt pin shaper: selectable level, level or pulse signalling
`timescale 1ns/1ns
`include "dma_pin_consts.svh"
module int_pin_drive import dma_pin_pkg::*; #(
  parameter int PULSE_CYC = `INT_PULSE_CYC
) (
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic req_in,
  input  wire logic pol_in,
  input  wire logic edge_in,
  output logic      pin_out
);
  if (PULSE_CYC < 1 || PULSE_CYC > 255) begin : g_bad_pulse
    $error("PULSE_CYC must be 1..255");
  end

  logic       req_q, next_req_q;
  logic [7:0] pulse, next_pulse;
  logic       level, next_level;

  // ========================================================================
  // next state
  always_comb begin
    next_req_q = req_in;
    next_pulse = pulse;
    if (req_in && !req_q) begin
      next_pulse = 8'(PULSE_CYC);
    end else if (pulse != 8'h00) begin
      next_pulse = pulse - 8'h01;
    end
    // pulse mode only reports the rising request, held level repeats nothing
    next_level = pin_level(edge_in ? (next_pulse != 8'h00) : req_in, pol_in);
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_q <= 1'b0;
      pulse <= 8'h00;
      level <= 1'b0;
    end else begin
      req_q <= next_req_q;
      pulse <= next_pulse;
      level <= next_level;
    end
  end

  assign pin_out = level;
endmodule : int_pin_drive

// [dma_pin_far_end.sv]
// far end: external dma controller, processor and attached disk in one party
`timescale 1ns/1ns
`include "dma_pin_consts.svh"
module dma_pin_far_end import dma_pin_pkg::*; (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       master_mode_in,
  input  wire logic       split_bus_in,
  input  wire logic [4:0] pol_in,
  input  wire logic       int_pol_in,
  input  wire logic       go_in,
  input  wire logic       read_in,
  input  wire logic       last_in,
  input  wire logic       ata_dreq_in,
  input  wire logic       ata_iordy_in,
  input  wire logic       ata_intrq_in,
  input  wire logic       cpu_req_in,
  output logic            done_out,
  output logic            cpu_go_out,
  output logic            ata_rd_out,
  output logic            ata_wr_out,
  output logic            ata_da2_out,
  output logic            int_active_out,
  dma_pins_if.far         pins
);

  far_state_t state, next_state;
  logic [7:0] tcnt, next_tcnt;
  logic       rd, next_rd;
  logic       last, next_last;
  logic       dior_q, next_dior_q;
  logic       diow_q, next_diow_q;
  logic       rd_p, next_rd_p;
  logic       wr_p, next_wr_p;
  logic       da2, next_da2;
  logic       dreq_act, dior_in, diow_in, strobing;

  assign dreq_act = !master_mode_in && pin_active(pins.dreq, pol_in[`POL_DREQ]);
  assign dior_in  = master_mode_in && pin_active(pins.dior, pol_in[`POL_DIOR]);
  assign diow_in  = master_mode_in && pin_active(pins.diow, pol_in[`POL_DIOW]);
  assign strobing = state == H_STROBE;

  // ========================================================================
  // controller role: one acknowledged strobe per request
  always_comb begin
    next_state = state;
    next_tcnt  = tcnt;
    next_rd    = rd;
    next_last  = last;
    unique case (state)
      H_IDLE: begin
        if (go_in && dreq_act) begin
          next_state = H_ACK;
          next_rd    = read_in;
          next_last  = last_in;
        end
      end
      H_ACK: begin
        next_state = H_STROBE;
        next_tcnt  = 8'h00;
      end
      H_STROBE: begin
        next_tcnt = tcnt + 8'h01;
        if (tcnt == 8'(`STROBE_CYC - 1)) begin
          next_state = H_HOLD;
        end
      end
      H_HOLD: begin
        next_state = H_IDLE;
      end
    endcase
    next_dior_q = dior_in;
    next_diow_q = diow_in;
    next_rd_p   = dior_in && !dior_q;
    next_wr_p   = diow_in && !diow_q;
    next_da2    = (dior_in || diow_in) ? pins.da2 : da2;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state  <= H_IDLE;
      tcnt   <= 8'h00;
      rd     <= 1'b0;
      last   <= 1'b0;
      dior_q <= 1'b0;
      diow_q <= 1'b0;
      rd_p   <= 1'b0;
      wr_p   <= 1'b0;
      da2    <= 1'b0;
    end else begin
      state  <= next_state;
      tcnt   <= next_tcnt;
      rd     <= next_rd;
      last   <= next_last;
      dior_q <= next_dior_q;
      diow_q <= next_diow_q;
      rd_p   <= next_rd_p;
      wr_p   <= next_wr_p;
      da2    <= next_da2;
    end
  end

  // ========================================================================
  // pins, each driven only in the direction that the mode gives this side
  assign pins.dack_far      = pin_level(state != H_IDLE, pol_in[`POL_DACK]);
  assign pins.dack_far_oe_n = master_mode_in;
  assign pins.dior_far      = pin_level(strobing && rd, pol_in[`POL_DIOR]);
  assign pins.dior_far_oe_n = master_mode_in;
  assign pins.diow_far      = pin_level(strobing && !rd, pol_in[`POL_DIOW]);
  assign pins.diow_far_oe_n = master_mode_in;
  assign pins.dreq_far      = pin_level(ata_dreq_in, pol_in[`POL_DREQ]);
  assign pins.dreq_far_oe_n = !master_mode_in;
  assign pins.ready_far     = ata_iordy_in;
  assign pins.ready_far_oe_n = !split_bus_in;
  assign pins.end_of_transfer_in           = pin_level(strobing && last, pol_in[`POL_EOT]);
  assign pins.intrq         = ata_intrq_in;

  // processor waits for ready high before each access
  assign cpu_go_out     = cpu_req_in && !split_bus_in && pins.ready;
  assign done_out       = state == H_HOLD;
  assign ata_rd_out     = rd_p;
  assign ata_wr_out     = wr_p;
  assign ata_da2_out    = da2;
  assign int_active_out = pin_active(pins.intr, int_pol_in);
endmodule : dma_pin_far_end

// [dma_pin_properties.sv]
// checker on the pin bundle between the device end and the far end
`timescale 1ns/1ns
module dma_pin_properties (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic dreq_dev_oe_n,
  input wire logic dreq_far_oe_n,
  input wire logic dack_dev_oe_n,
  input wire logic dack_far_oe_n,
  input wire logic dior_dev_oe_n,
  input wire logic dior_far_oe_n,
  input wire logic diow_dev_oe_n,
  input wire logic diow_far_oe_n,
  input wire logic ready_dev_oe_n,
  input wire logic ready_far_oe_n,
  input wire logic dior,
  input wire logic diow,
  input wire logic da2
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // ======
  // one driver per pin; strobes default active low
  AST_DREQ_ONE: assert property (dreq_dev_oe_n || dreq_far_oe_n)
    else $error("request pin driven by both ends");
  AST_DACK_ONE: assert property (!dack_far_oe_n |-> dack_dev_oe_n)
    else $error("acknowledge pin driven by both ends");
  AST_DIOR_ONE: assert property (!(!dior_dev_oe_n && !dior_far_oe_n))
    else $error("read strobe driven by both ends");
  AST_DIOW_ONE: assert property (!diow_dev_oe_n |-> diow_far_oe_n)
    else $error("write strobe driven by both ends");
  AST_READY_ONE: assert property (ready_dev_oe_n || ready_far_oe_n)
    else $error("ready pin driven by both ends");
  AST_DIOR_WIDTH: assert property ($fell(dior) |-> (!dior) [*3])
    else $error("read strobe shorter than three cycles");
  AST_DIOW_WIDTH: assert property ($fell(diow) |-> (!diow) [*3])
    else $error("write strobe shorter than three cycles");
  AST_DA2_HOLD: assert property ($fell(diow) || $fell(dior) |=> $stable(da2) [*2])
    else $error("address bit two moved during strobe");
  cover property ($fell(dior));
  cover property ($fell(diow));
  cover property (!dreq_far_oe_n);
endmodule : dma_pin_properties

// [dma_ata_pin_interface_test.sv]
// self-checking bench: device end and far end joined by the pin bundle
`timescale 1ns/1ns
module dma_ata_pin_interface_test;
  logic mclk_in = 0, rst_n_in = 0, psel = 0, pen = 0, pwr = 0, busy = 0, dmq = 0;
  logic mm = 0, sb = 0, go = 0, rdin = 0, last = 0, adq = 0, ardyi = 1, aint = 0, ipol = 0;
  logic [4:0] pol = 5'h01;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, rds, wrs, end_of_transfer_in, done, cgo, ard, awr, ada2, iact, serr;
  int error_cnt = 0, checks_done = 0;
  dma_pins_if pins ();
  dma_pin_device i_dma_pin_device (.mclk_in, .rst_n_in, .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq), .core_busy_in(busy),
    .dma_req_in(dmq), .rd_strobe_out(rds), .wr_strobe_out(wrs), .eot_out(end_of_transfer_in),
    .pins(pins.device));
  dma_pin_far_end i_dma_pin_far_end (.mclk_in, .rst_n_in, .master_mode_in(mm),
    .split_bus_in(sb), .pol_in(pol), .int_pol_in(ipol), .go_in(go), .read_in(rdin),
    .last_in(last), .ata_dreq_in(adq), .ata_iordy_in(ardyi), .ata_intrq_in(aint),
    .cpu_req_in(1'b1), .done_out(done), .cpu_go_out(cgo), .ata_rd_out(ard),
    .ata_wr_out(awr), .ata_da2_out(ada2), .int_active_out(iact), .pins(pins.far));
  dma_pin_properties i_dma_pin_properties (.mclk_in, .rst_n_in,
    .dreq_dev_oe_n(pins.dreq_dev_oe_n), .dreq_far_oe_n(pins.dreq_far_oe_n),
    .dack_dev_oe_n(pins.dack_dev_oe_n), .dack_far_oe_n(pins.dack_far_oe_n),
    .dior_dev_oe_n(pins.dior_dev_oe_n), .dior_far_oe_n(pins.dior_far_oe_n),
    .diow_dev_oe_n(pins.diow_dev_oe_n), .diow_far_oe_n(pins.diow_far_oe_n),
    .ready_dev_oe_n(pins.ready_dev_oe_n), .ready_far_oe_n(pins.ready_far_oe_n),
    .dior(pins.dior), .diow(pins.diow), .da2(pins.da2));
  initial forever #5 mclk_in = ~mclk_in;
  // ======
  task automatic chk(input logic [31:0] s, e, input string nm);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic finish_test();
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick
  // starts on a fresh edge so back-to-back calls never assign twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_in);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in) pen <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      finish_test();
    end
  endtask : apb
  // ======
  task automatic basic();
    apb(0, 8'h00, 0);
    chk(rd, 32'h002, "ctrl reset");
    apb(0, 8'h40, 0);
    chk({rd[0], serr}, 2'h1, "unmapped");
    busy <= 1'b1;
    tick(3);
    chk(pins.ready, 0, "ready busy");
    chk(cgo, 0, "cpu held");
    busy <= 1'b0;
    tick(3);
    chk({pins.ready, cgo}, 2'h3, "ready free");
  endtask : basic
  task automatic slave(input logic r, l, input int er, ew);
    int nr, nw, ne;
    nr = 0;
    nw = 0;
    ne = 0;
    @(posedge mclk_in);
    {dmq, go, rdin, last} <= {2'h3, r, l};
    for (int i = 0; i < 30 && done !== 1'b1; i++) begin
      @(posedge mclk_in);
      nr += rds;
      nw += wrs;
      ne += end_of_transfer_in;
    end
    {dmq, go, last} <= 3'h0;
    chk(done, 1, "slave done");
    chk({pins.dreq_dev_oe_n, pins.dack_dev_oe_n}, 2'h1, "slave drivers");
    chk(nr, er, "slave reads");
    chk(nw, ew, "slave writes");
    chk(ne > 0, l, "eot seen");
  endtask : slave
  task automatic irq_lvl();
    apb(0, 8'h08, 0);
    chk(rd[1], 1, "eot status");
    apb(1, 8'h04, 32'h2);
    tick(2);
    chk({irq, iact}, 2'h3, "int level");
    apb(1, 8'h08, 32'h2);
    tick(2);
    chk({irq, iact}, 2'h0, "int cleared");
  endtask : irq_lvl
  task automatic master(input logic [31:0] ctl, input logic [4:0] p, input int er, ew);
    int nr, nw;
    nr = 0;
    nw = 0;
    apb(1, 8'h00, ctl);
    mm <= 1'b1;
    pol <= p;
    adq <= 1'b1;
    apb(1, 8'h0c, 32'h2);
    repeat (80) begin
      @(posedge mclk_in);
      nr += ard;
      nw += awr;
    end
    adq <= 1'b0;
    apb(0, 8'h08, 0);
    chk(rd[0], 1, "dma done");
    chk(nr, er, "disk reads");
    chk(nw, ew, "disk writes");
    chk({pins.dreq_dev_oe_n, pins.dack_far_oe_n}, 2'h3, "master drivers");
    apb(1, 8'h08, 32'h1);
  endtask : master
  task automatic pio();
    apb(1, 8'h00, 32'h101);
    sb <= 1'b1;
    ardyi <= 1'b0;
    apb(1, 8'h0c, 32'h30000);
    tick(8);
    chk({pins.ready_dev_oe_n, pins.diow}, 2'h2, "pio held");
    ardyi <= 1'b1;
    tick(6);
    apb(0, 8'h08, 0);
    chk({rd[3], ada2}, 2'h3, "pio done da2");
  endtask : pio
  task automatic intr_chk();
    int n;
    n = 0;
    apb(1, 8'h04, 32'h0);
    apb(1, 8'h00, 32'h1c1);
    ipol <= 1'b1;
    aint <= 1'b1;
    tick(3);
    apb(0, 8'h08, 0);
    chk(rd[2], 1, "intrq status");
    apb(1, 8'h04, 32'h4);
    repeat (12) begin
      @(posedge mclk_in);
      n += iact;
    end
    chk(n, 4, "int pulse width");
  endtask : intr_chk
  initial begin
    tick(5);
    rst_n_in <= 1'b1;
    basic();
    slave(1'b1, 1'b1, 1, 0);
    irq_lvl();
    slave(1'b0, 1'b0, 0, 1);
    master(32'h003, 5'h01, 0, 2);
    // second run takes the request line active low
    master(32'h201, 5'h00, 2, 0);
    pio();
    intr_chk();
    finish_test();
  end
endmodule : dma_ata_pin_interface_test
